// ---- design/mft_touch.sv ----
// Module: multi-frequency touch measurement, combining, averaging and status
//
// Functional notes
// (R1) Value majority: scale, add closest pair
// (R2) Weight differences: first 1, second 2, third 1.5
// (R3) Differences 1-2, 1-3, 2-3 pick pair
// (R4) Judgment majority: two of three decisions
// (R5) Majority bit 1 judgment, 0 value
// (R6) Judgment majority only for button types
// (R7) Measure three frequencies then combine
// (R8) Pulse = clock/source/state/pulse-div times multiplier
// (R9) Sense count sets 64/128/256us windows
// (R10) Drive pulse phase-shifted and frequency-spread
// (R11) Spread reset: off 0, mode 0, count 3
// (R12) Base clock per-pin divider after source select
// (R13) Shield follows drive pulse, self mode only
// (R14) Abnormal measurement sets its status flag
// (R15) Flags taken at completion, cleared on read
// (R16) Averaged result readable, combined value also
// (R17) Running mean over configured window per channel
// (R18) Diagnosis runs apart from touch measurement
// (R19) Host waits 1ms after diagnosis
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`default_nettype none
module mft_touch
	import mft_pkg::*;
#(
	parameter int unsigned CW   = 16,  // sensor counter width
	parameter int unsigned WMAX = 8    // longest averaging window
)(
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic [5:0]  addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic        osc_in,
	input  wire logic        abn0_in,
	input  wire logic        abn1_in,
	output logic             drive_pulse,
	output logic             shield_out,
	output logic             nonmeas_out,
	output logic             diag_sel,
	output logic      [3:0]  diag_kind,
	output logic             touch,
	output logic             irq
);
	localparam int unsigned VW  = CW + 1;   // corrected value width
	localparam int unsigned SW  = VW + 1;   // pair sum width
	localparam int unsigned UW  = SW + 3;   // running sum width
	localparam int unsigned PW  = $clog2(WMAX);
	localparam int unsigned AW  = 2 + PW;

	// Register file
	logic [31:0]   cfg;                    // Configuration word
	logic [23:0]   mult;                   // frequency_multiplier_n, one byte each
	logic [15:0]   scl [NFREQ];            // Per-frequency correction factor
	logic [15:0]   thr;                    // Touch threshold
	logic [31:0]   pdiv;                   // drive_pulse_divider, one byte per pin
	logic [2:0]    mask;                   // Interrupt mask
	logic [2:0]    stat;                   // Sticky events
	logic [2:0]    err;                    // Abnormal flags, clear on read
	logic [1:0]    chan;                   // Channel being measured
	logic [3:0]    dtype;                  // Diagnosis type
	// Sequencer and datapath state
	mft_state_e    state;
	logic [1:0]    fi;                     // Frequency index
	logic          diag_run;               // Current run is a diagnosis
	logic [2:0]    s1, s2;                 // Pin synchronisers
	logic          osc_d;                  // Edge detector stage
	logic [9:0]    pre_cnt;                // State clock prescaler
	logic [7:0]    win_cnt;                // State clock ticks in window
	logic [CW-1:0] cnt;                    // Sensor counter
	logic [17:0]   acc;                    // Pulse phase accumulator
	logic [7:0]    lfsr;                   // Spread source
	logic [2:0]    pend;                   // Flags gathered during the run
	logic [VW-1:0] val [NFREQ];            // Corrected values
	logic [SW-1:0] comb;                   // Combined value
	logic [SW-1:0] avg;                    // Averaged value
	logic [CW-1:0] diag_res;               // Raw diagnosis count
	logic          touch_nx;               // Decision waiting for the average
	logic [UW-1:0] rsum [NCH];             // Running sums
	logic [PW-1:0] ptr  [NCH];             // Oldest slot
	logic [PW:0]   fill [NCH];             // Valid entries
	mft_mem_if #(.W(SW), .AW(AW)) hm ();

	// Address match, shared by write and read decode
	function automatic logic sel(input logic [5:0] a, input logic [5:0] b);
		return a == b;
	endfunction : sel

	// Distance between two values, used for all three pairs
	function automatic logic [VW-1:0] absd(input logic [VW-1:0] a, input logic [VW-1:0] b);
		return (a > b) ? a - b : b - a;
	endfunction : absd

	// Configuration fields
	wire [3:0] snum      = cfg[F_SNUM +: 4];
	wire [1:0] stype     = cfg[F_TYPE +: 2];
	wire       shld_en   = cfg[F_SHLD];
	wire       src_sel   = cfg[F_SRC];
	wire       spread_off = cfg[F_SOFF];
	wire       smod      = cfg[F_SMOD];
	wire [3:0] scnt      = cfg[F_SCNT +: 4];
	wire [1:0] lg        = cfg[F_AVG +: 2];
	wire [7:0] stdiv     = cfg[F_STDIV +: 8];
	// (R5) majority select
	// (R6) judgment only on buttons
	wire       jm        = cfg[F_MAJ] & (stype == T_SELF | stype == T_MUT);

	// Bus decode
	wire       idle      = state == S_IDLE;
	wire       meas      = state == S_MEAS;
	wire       wr_ctrl   = ce & wr & sel(addr, A_CTRL);
	wire       wr_stat   = ce & wr & sel(addr, A_STAT);
	wire       rd_err    = ce & rd & sel(addr, A_ERR);
	wire       start_req = wr_ctrl & idle & wdata[C_START];
	// A diagnosis type out of range is ignored
	wire       diag_req  = wr_ctrl & idle & wdata[C_DIAG] & ~wdata[C_START]
	                       & (wdata[C_DTYPE +: 4] < 4'(NDIAG));
	wire       go        = start_req | diag_req;

	// (R12) base clock: source select then per-pin divider
	// (R8) pulse rate scales with the multiplier
	wire [9:0]  st_per   = ({2'h0, stdiv} + 10'h001) << src_sel;
	wire [7:0]  pd_cur   = pdiv[chan*8 +: 8];
	wire [7:0]  m_cur    = mult[fi*8 +: 8];
	wire [17:0] base_lim = {8'h00, st_per} * {10'h000, pd_cur};
	// (R10) spread and phase shift from the shift register
	wire [17:0] jit      = spread_off ? 18'h00000 : {14'h0000, lfsr[3:0] & scnt};
	wire [17:0] lim_j    = smod ? base_lim - jit : base_lim + jit;
	wire [17:0] phase0   = spread_off ? 18'h00000 : {14'h0000, lfsr[7:4]};
	wire [17:0] acc_sum  = acc + {9'h000, m_cur, 1'b0};
	wire        wrap     = meas & (acc_sum >= lim_j);
	wire        next_pulse = meas & (drive_pulse ^ wrap);
	// (R9) window = (count+1) x 8 ticks of state clock
	wire [7:0]  win_len  = 8'(({4'h0, snum} + 8'h01) * UNIT_TICKS);
	wire        st_tick  = meas & (pre_cnt == st_per - 10'h001);
	wire        win_end  = st_tick & (win_cnt == win_len - 8'h01);
	wire        meas_done = win_end & (diag_run | fi == 2'h2);
	wire        osc_rise = s2[0] & ~osc_d;
	wire        cnt_full = cnt == {CW{1'b1}};
	// Count with this cycle's rise, so a window ending on a rise loses nothing; saturates rather than wrapping
	wire [CW-1:0] cnt_nx = (osc_rise && !cnt_full) ? cnt + CW'(1) : cnt;
	wire [31:0] prod     = {16'h0000, cnt_nx} * {16'h0000, scl[fi]};

	// (R3) pair differences and choice
	wire [VW-1:0] a1 = absd(val[0], val[1]);
	wire [VW-1:0] a2 = absd(val[0], val[2]);
	wire [VW-1:0] a3 = absd(val[1], val[2]);
	// (R2) weights 1, 2 and 1.5, all doubled
	wire [VW+1:0] w1 = {1'b0, a1, 1'b0};
	wire [VW+1:0] w2 = {a2, 2'b00};
	wire [VW+1:0] w3 = {2'b00, a3} + {1'b0, a3, 1'b0};
	wire mft_pair_e pair = (w1 <= w2 && w1 <= w3) ? P12 : (w2 <= w3) ? P13 : P23;
	// (R1) sum of the closest pair
	wire [SW-1:0] psum = (pair == P12) ? {1'b0, val[0]} + {1'b0, val[1]} :
	                     (pair == P13) ? {1'b0, val[0]} + {1'b0, val[2]} :
	                                     {1'b0, val[1]} + {1'b0, val[2]};
	wire          t_vmm = psum >= {1'b0, thr, 1'b0};
	// (R4) one decision per value, two of three win
	wire [2:0]    tj  = {val[2] >= {1'b0, thr}, val[1] >= {1'b0, thr}, val[0] >= {1'b0, thr}};
	wire          maj = (tj[0] & tj[1]) | (tj[0] & tj[2]) | (tj[1] & tj[2]);

	// (R17) running mean over the window
	wire [PW:0]   len    = (PW+1)'(1) << lg;
	wire [SW-1:0] oldest = (fill[chan] >= len) ? hm.rdata : {SW{1'b0}};
	wire [UW-1:0] new_sum = rsum[chan] + {3'h0, comb} - {3'h0, oldest};
	wire [UW-1:0] avg_full = new_sum >> lg;
	wire [PW-1:0] ptr_nx  = (ptr[chan] + PW'(1)) & PW'(len - (PW+1)'(1));
	assign hm.we    = ce & (state == S_AVG);
	assign hm.waddr = {chan, ptr[chan]};
	assign hm.wdata = comb;
	assign hm.raddr = {chan, ptr[chan]};

	// Events and flags
	wire [2:0] err_set  = meas_done ? pend : 3'h0;
	wire [2:0] stat_set = {meas_done & diag_run, |err_set, state == S_AVG};
	wire [2:0] stat_clr = wr_stat ? wdata[2:0] : 3'h0;

	// Read selection
	wire [31:0] next_rdata =
		sel(addr, A_CTRL) ? {24'h0, dtype, chan, 1'b0, ~idle} :
		sel(addr, A_CFG)  ? cfg :
		sel(addr, A_MULT) ? {8'h00, mult} :
		sel(addr, A_SCL0) ? {16'h0, scl[0]} :
		sel(addr, A_SCL0 + 6'h04) ? {16'h0, scl[1]} :
		sel(addr, A_SCL0 + 6'h08) ? {16'h0, scl[2]} :
		sel(addr, A_THR)  ? {16'h0, thr} :
		sel(addr, A_STAT) ? {29'h0, stat} :
		sel(addr, A_MASK) ? {29'h0, mask} :
		sel(addr, A_ERR)  ? {29'h0, err} :
		// (R16) averaged value with its decision
		sel(addr, A_RES)  ? {touch, 31'(avg)} :
		sel(addr, A_COMB) ? 32'(comb) :
		sel(addr, A_DIAG) ? 32'(diag_res) :
		sel(addr, A_PDIV) ? pdiv : 32'h0000_0000;

	// Storage of the history
	mft_hist #(.W(SW), .AW(AW)) u_hist (
		.ref_clk (ref_clk),
		.ce      (ce),
		.m       (hm.mem)
	);

	// Writable configuration
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			// (R11) spread fixed at reset
			cfg  <= CFG_RST;
			mult <= MULT_RST;
			thr  <= THR_RST;
			pdiv <= PDIV_RST;
			mask <= 3'h0;
		end else if (ce && wr) begin
			case (addr)
				A_CFG:   cfg  <= wdata;
				A_MULT:  mult <= wdata[23:0];
				A_THR:   thr  <= wdata[15:0];
				A_PDIV:  pdiv <= wdata;
				A_MASK:  mask <= wdata[2:0];
				default: ;
			endcase
		end
	end

	// One correction factor per frequency
	for (genvar g = 0; g < NFREQ; g++) begin : g_scl
		always_ff @(posedge ref_clk) begin
			if (!rstn) begin
				scl[g] <= SCL_RST;
			end else if (ce && wr && sel(addr, A_SCL0 + 6'(4 * g))) begin
				scl[g] <= wdata[15:0];
			end
		end
	end

	// Sequencer: three frequencies, combine, average
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			state    <= S_IDLE;
			fi       <= 2'h0;
			diag_run <= 1'b0;
			chan     <= 2'h0;
			dtype    <= 4'h0;
		end else if (ce) begin
			case (state)
				S_IDLE: if (go) begin
					state    <= S_MEAS;
					fi       <= 2'h0;
					diag_run <= diag_req;
					chan     <= wdata[C_CHAN +: 2];
					dtype    <= wdata[C_DTYPE +: 4];
				end
				// (R7) step through three frequencies
				// (R18) diagnosis stops after one window
				S_MEAS: if (win_end) begin
					if (diag_run) state <= S_IDLE;
					else if (fi == 2'h2) state <= S_COMB;
					else fi <= fi + 2'h1;
				end
				S_COMB:  state <= S_AVG;
				default: state <= S_IDLE;
			endcase
		end
	end

	// Pin synchronisers; only the second stage is looked at
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s1    <= 3'h0;
			s2    <= 3'h0;
			osc_d <= 1'b0;
		end else if (ce) begin
			s1    <= {abn1_in, abn0_in, osc_in};
			s2    <= s1;
			osc_d <= s2[0];
		end
	end

	// Window timing, counting and pulse generation
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pre_cnt <= 10'h000;
			win_cnt <= 8'h00;
			cnt     <= {CW{1'b0}};
			acc     <= 18'h00000;
		end else if (ce) begin
			if (go || win_end) begin
				pre_cnt <= 10'h000;
				win_cnt <= 8'h00;
				cnt     <= {CW{1'b0}};
				acc     <= phase0;
			end else if (meas) begin
				pre_cnt <= st_tick ? 10'h000 : pre_cnt + 10'h001;
				win_cnt <= win_cnt + {7'h00, st_tick};
				// Counter saturates rather than wrapping
				cnt <= cnt_nx;
				acc <= wrap ? acc_sum - lim_j : acc_sum;
			end
		end
	end

	// Pulse, shield and spread register; shield uses the same next value so it stays in phase
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			drive_pulse <= 1'b0;
			shield_out  <= 1'b0;
			nonmeas_out <= 1'b0;
			lfsr        <= 8'hA5;
		end else if (ce) begin
			drive_pulse <= next_pulse;
			// (R13) shield only for self-capacitance
			shield_out  <= next_pulse & shld_en & (stype == T_SELF) & ~diag_run;
			nonmeas_out <= next_pulse & shld_en & (stype == T_SELF) & ~diag_run;
			if (wrap) lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		end
	end

	// Corrected values and abnormal conditions of the run
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pend     <= 3'h0;
			diag_res <= {CW{1'b0}};
			for (int i = 0; i < NFREQ; i++) val[i] <= {VW{1'b0}};
		end else if (ce) begin
			// (R14) overflow and current flags gathered
			if (go) pend <= 3'h0;
			else if (meas) pend <= pend | {osc_rise & cnt_full, s2[2], s2[1]};
			if (win_end && diag_run) diag_res <= cnt_nx;
			// (R1) scale each result to the first frequency
			if (win_end && !diag_run) val[fi] <= prod[FRAC +: VW];
		end
	end

	// Combining and averaging
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			comb     <= {SW{1'b0}};
			avg      <= {SW{1'b0}};
			touch_nx <= 1'b0;
			touch    <= 1'b0;
			for (int i = 0; i < NCH; i++) begin
				rsum[i] <= {UW{1'b0}};
				ptr[i]  <= {PW{1'b0}};
				fill[i] <= {(PW+1){1'b0}};
			end
		end else if (ce) begin
			if (state == S_COMB) begin
				comb     <= psum;
				touch_nx <= jm ? maj : t_vmm;
			end
			if (state == S_AVG) begin
				rsum[chan] <= new_sum;
				ptr[chan]  <= ptr_nx;
				if (fill[chan] < len) fill[chan] <= fill[chan] + (PW+1)'(1);
				avg   <= avg_full[SW-1:0];
				touch <= touch_nx;
			end
		end
	end

	// Status, error flags, interrupt and read data
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			stat      <= 3'h0;
			err       <= 3'h0;
			irq       <= 1'b0;
			rdata     <= 32'h0000_0000;
			diag_sel  <= 1'b0;
			diag_kind <= 4'h0;
		end else if (ce) begin
			stat  <= (stat & ~stat_clr) | stat_set;
			// (R15) taken at completion, read clears, set wins
			err   <= (err & ~{3{rd_err}}) | err_set;
			irq   <= |(stat & mask);
			rdata <= rd ? next_rdata : 32'h0000_0000;
			diag_sel  <= meas & diag_run;
			diag_kind <= (meas & diag_run) ? dtype : 4'h0;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	// (R11) spread defaults
	spread_init_a: assert property (!$past(rstn) |-> !spread_off && !smod && scnt == 4'h3) // (R11)
		else $error("spread defaults wrong after reset");
	// (R2) weighted choice
	pair_pick_a: assert property ((pair != P12) == (2 * a1 > 4 * a2 || 2 * a1 > 3 * a3)) // (R2)
		else $error("pair 1+2 choice disagrees with weighted distances");
	// (R4) majority vote
	jmm_vote_a: assert property (state == S_COMB && ce && jm ##1 ce |=> touch == $past(maj, 2)) // (R4)
		else $error("judgment majority result wrong");
	// (R6) judgment gating
	jmm_gate_a: assert property (jm |-> stype == T_SELF || stype == T_MUT) // (R6)
		else $error("judgment majority on non-button type");
	// (R13) shield phase
	shield_phase_a: assert property (shield_out |-> drive_pulse && shld_en && stype == T_SELF) // (R13)
		else $error("shield active without matching drive pulse");
	// (R15) read clears
	err_clear_a: assert property (rd_err && err_set == 3'h0 |=> err == 3'h0) // (R15)
		else $error("error flags survived a read");
	// (R14) overflow flag
	ovf_flag_a: assert property (ce && meas_done && pend[E_OVF_B] |=> err[E_OVF_B]) // (R14)
		else $error("overflow flag not set");
	// (R9) window length
	meas_len_a: assert property (win_end |-> win_cnt == 8'(({4'h0, snum} + 8'h01) * 8) - 8'h01) // (R9)
		else $error("measurement window length wrong");
	irq_level_a: assert property (ce |=> irq == $past(|(stat & mask)))
		else $error("interrupt does not follow masked status");
	vmm_done_c: cover property (state == S_AVG && ce && !jm);
	jmm_done_c: cover property (state == S_AVG && ce && jm && touch_nx);
	diag_done_c: cover property (ce && meas_done && diag_run);
	irq_rise_c: cover property ($rose(irq));
endmodule : mft_touch
`default_nettype wire

// ---- design/mft_pkg.sv ----
// Package: register map, field layout, reset values and timing of the touch judgment block
`default_nettype none
package mft_pkg;
	localparam int unsigned CLK_KHZ       = 50000;  // ref_clk rate
	localparam int unsigned STATE_CLK_KHZ = 500;    // nominal state clock
	localparam int unsigned MEAS_UNIT_NS  = 16000;  // measurement time per sense-count step
	localparam int unsigned UNIT_TICKS    = MEAS_UNIT_NS * STATE_CLK_KHZ / 1000000;
	localparam int unsigned NFREQ         = 3;      // frequencies combined per channel
	localparam int unsigned NCH           = 4;      // channels (sense pins)
	localparam int unsigned FRAC          = 12;     // fraction bits of scale factors
	localparam int unsigned NDIAG         = 9;      // diagnosis types
	// Register byte offsets
	localparam logic [5:0]  A_CTRL        = 6'h00;
	localparam logic [5:0]  A_CFG         = 6'h04;
	localparam logic [5:0]  A_MULT        = 6'h08;
	localparam logic [5:0]  A_SCL0        = 6'h0C;  // three scale words follow
	localparam logic [5:0]  A_THR         = 6'h18;
	localparam logic [5:0]  A_STAT        = 6'h1C;
	localparam logic [5:0]  A_MASK        = 6'h20;
	localparam logic [5:0]  A_ERR         = 6'h24;
	localparam logic [5:0]  A_RES         = 6'h28;
	localparam logic [5:0]  A_COMB        = 6'h2C;
	localparam logic [5:0]  A_DIAG        = 6'h30;
	localparam logic [5:0]  A_PDIV        = 6'h34;
	// Configuration field positions
	localparam int unsigned F_SNUM        = 0;      // sense_count_field, 4 bits
	localparam int unsigned F_MAJ         = 4;      // 1 judgment, 0 value majority
	localparam int unsigned F_TYPE        = 5;      // sensor type, 2 bits
	localparam int unsigned F_SHLD        = 7;      // shield enable
	localparam int unsigned F_SRC         = 8;      // count_source_select: 1 halves
	localparam int unsigned F_SOFF        = 9;      // spread_off_bit
	localparam int unsigned F_SMOD        = 10;     // spread_mode_field
	localparam int unsigned F_SCNT        = 12;     // spread_count_field, 4 bits
	localparam int unsigned F_AVG         = 16;     // log2 of averaging window, 2 bits
	localparam int unsigned F_STDIV       = 24;     // state clock divider minus one, 8 bits
	// Control, status and error bits
	localparam int unsigned C_START       = 0;
	localparam int unsigned C_DIAG        = 1;
	localparam int unsigned C_CHAN        = 2;      // 2 bits
	localparam int unsigned C_DTYPE       = 4;      // 4 bits
	localparam int unsigned S_DONE_B      = 0;
	localparam int unsigned S_ERR_B       = 1;
	localparam int unsigned S_DIAG_B      = 2;
	localparam int unsigned E_OVF_B       = 2;      // bits 0 and 1: current abnormal
	// Sensor types
	localparam logic [1:0]  T_SELF        = 2'h0;
	localparam logic [1:0]  T_MUT         = 2'h1;
	// Reset values
	localparam logic [31:0] CFG_RST       = 32'h3100_310F;
	localparam logic [23:0] MULT_RST      = 24'h06_05_04;
	localparam logic [15:0] SCL_RST       = 16'h1000;
	localparam logic [15:0] THR_RST       = 16'h1E00;
	localparam logic [31:0] PDIV_RST      = 32'h1010_1010;
	typedef enum logic [1:0] {S_IDLE, S_MEAS, S_COMB, S_AVG} mft_state_e;
	typedef enum logic [1:0] {P12, P13, P23} mft_pair_e;
endpackage : mft_pkg
`default_nettype wire

// ---- design/mft_mem_if.sv ----
// Interface: history memory port between sequencer and storage
`default_nettype none
interface mft_mem_if #(parameter int unsigned W = 18, parameter int unsigned AW = 5);
	logic          we;     // Write this cycle
	logic [AW-1:0] waddr;  // Write address
	logic [W-1:0]  wdata;  // Write data
	logic [AW-1:0] raddr;  // Read address
	logic [W-1:0]  rdata;  // Registered read data
	modport host (output we, waddr, wdata, raddr, input rdata);
	modport mem  (input we, waddr, wdata, raddr, output rdata);
endinterface : mft_mem_if
`default_nettype wire

// ---- design/mft_hist.sv ----
// Module: averaging history memory with registered read data
`default_nettype none
module mft_hist
	import mft_pkg::*;
#(
	parameter int unsigned W  = 18,
	parameter int unsigned AW = 5
)(
	input  wire logic ref_clk,
	input  wire logic ce,
	mft_mem_if.mem    m
);
	// Storage array, no reset: validity is tracked by the fill counts
	logic [W-1:0] mem [2**AW];

	// Write port and registered read, both frozen by ce
	always_ff @(posedge ref_clk) begin
		if (ce) begin
			if (m.we) begin
				mem[m.waddr] <= m.wdata;
			end
			m.rdata <= mem[m.raddr];
		end
	end
endmodule : mft_hist
`default_nettype wire

// ---- bench/mft_osc.sv ----
// Partner: sensing front end, oscillator and abnormal-current detectors
`default_nettype none
module mft_osc (
	input  wire logic       ref_clk,
	input  wire logic [1:0] abn_req,
	output logic            osc_in,
	output logic            abn0_in,
	output logic            abn1_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Period of two clocks, so any whole window counts exactly half its length
	logic osc_q = 1'b0;  // Oscillator state
	always @(negedge ref_clk) osc_q <= ~osc_q;
	assign osc_in = osc_q;
	assign abn0_in = abn_req[0];
	assign abn1_in = abn_req[1];
endmodule : mft_osc
`default_nettype wire

// ---- bench/mft_touch_bench.sv ----
// Bench: touch judgment block against a behavioural model
`default_nettype none
module mft_touch_bench
	import mft_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        ref_clk = 1'b0;  // 50 MHz clock
	logic        rstn    = 1'b0;  // Active-low reset
	logic        ce      = 1'b1;  // Running, except low for one write in the ce hold check
	logic [5:0]  addr    = 6'h00; // Bus address
	logic [31:0] wdata   = 32'h0; // Bus write data
	logic        wr      = 1'b0;  // Write strobe
	logic        rd      = 1'b0;  // Read strobe
	logic [1:0]  abn_req = 2'h0;  // Abnormal requests to partner
	logic [31:0] seed = 32'hFEA65F81;  // Random state
	logic        shld = 1'b0;     // Shield expected to follow drive
	logic [31:0] rdata;
	logic        osc_in, abn0_in, abn1_in, drive_pulse, shield_out, nonmeas_out, diag_sel, touch, irq;
	logic [3:0]  diag_kind;
	int          n_fail = 0;
	int          tests_run = 0;
	int          hq[4][$];        // Combined sums per channel
	logic [5:0]  ra[8] = '{A_CFG, A_MULT, A_SCL0, 6'h14, A_THR, A_PDIV, A_MASK, 6'h3C};
	logic [31:0] rv[8] = '{CFG_RST, {8'h0, MULT_RST}, {16'h0, SCL_RST}, {16'h0, SCL_RST},
		{16'h0, THR_RST}, PDIV_RST, 32'h0, 32'h0};
	always #10 ref_clk = ~ref_clk;
	mft_osc fe (.ref_clk, .abn_req, .osc_in, .abn0_in, .abn1_in);
	mft_touch uut (.ref_clk, .rstn, .ce, .addr, .wdata, .wr, .rd, .rdata, .osc_in, .abn0_in, .abn1_in,
		.drive_pulse, .shield_out, .nonmeas_out, .diag_sel, .diag_kind, .touch, .irq);
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : xs
	function automatic int ab(input int x);
		return (x < 0) ? -x : x;
	endfunction : ab
	task automatic end_sim();
		$display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_sim
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	// Strobes drop one edge before the next task raises them again
	task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk);
		wr <= 1'b0;
	endtask : bus_wr
	task automatic bus_rd(input logic [5:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : bus_rd
	task automatic run_diag(input int k);
		logic [31:0] d;
		int j;
		bus_wr(A_CTRL, 32'(k << 4 | 2));
		repeat (2) @(posedge ref_clk);
		#1 chk({27'h0, diag_sel, diag_kind}, (k < 9) ? 32'(16 | k) : 32'h0, "diag");
		d = 32'h0;
		for (j = 0; j < 200 && k < 9 && !d[S_DIAG_B]; j++)
			bus_rd(A_STAT, d);
		bus_rd(A_DIAG, d);
		chk(d, 32'h40, "raw");
		bus_rd(A_CTRL, d);
		chk(d & 32'h1, 32'h0, "idle");
		bus_wr(A_STAT, 32'h7);
	endtask : run_diag
	task automatic run_meas(input int ch, input int maj, input int typ, input int avg, input logic [1:0] err);
		int v[3];
		int s;
		int a;
		int k;
		int th;
		logic t;
		logic [31:0] d;
		logic [31:0] m;
		m = xs() & 32'h1;
		// Thresholds straddle the corrected values so both decisions occur
		th = 30 + int'(xs() % 36);
		bus_wr(A_CFG, 32'h308F | 32'(maj << 4 | typ << 5 | avg << 16));
		bus_wr(A_THR, 32'(th));
		bus_wr(A_MASK, m);
		for (k = 0; k < 3; k++) begin
			d = 32'h800 + (xs() & 32'hFFF);
			bus_wr(A_SCL0 + 6'(4 * k), d);
			v[k] = (64 * int'(d)) >> 12;
		end
		// Doubled weights keep the ratios 1 : 2 : 1.5 exact
		s = (2 * ab(v[0] - v[1]) <= 4 * ab(v[0] - v[2]) && 2 * ab(v[0] - v[1]) <= 3 * ab(v[1] - v[2]))
			? v[0] + v[1] : (4 * ab(v[0] - v[2]) <= 3 * ab(v[1] - v[2])) ? v[0] + v[2] : v[1] + v[2];
		hq[ch].push_back(s);
		a = 0;
		for (k = 0; k < (1 << avg); k++)
			if (hq[ch].size() > k)
				a += hq[ch][hq[ch].size() - 1 - k];
		a = a >> avg;
		t = (maj == 1 && typ < 2) ? (int'(v[0] >= th) + int'(v[1] >= th) + int'(v[2] >= th) >= 2) : (a >= 2 * th);
		abn_req <= err;
		shld = (typ == 0);
		bus_wr(A_CTRL, 32'(ch << 2 | 1));
		bus_wr(A_CTRL, 32'(ch << 2 | 1));
		bus_rd(A_CTRL, d);
		chk(d & 32'hD, 32'(ch << 2 | 1), "busy");
		d = 32'h0;
		for (k = 0; k < 300 && !d[S_DONE_B]; k++)
			bus_rd(A_STAT, d);
		abn_req <= 2'h0;
		chk(d, (err != 2'h0) ? 32'h3 : 32'h1, "stat");
		chk({31'h0, irq}, m, "irq");
		bus_rd(A_COMB, d);
		chk(d, 32'(s), "comb");
		bus_rd(A_RES, d);
		chk({14'h0, d[17:0]}, 32'(a), "avg");
		if (avg == 0)
			chk({30'h0, d[31], touch}, {30'h0, t, t}, "touch");
		bus_rd(A_ERR, d);
		chk(d, 32'(err), "err");
		bus_rd(A_ERR, d);
		chk(d, 32'h0, "err clear");
		bus_wr(A_STAT, 32'h7);
		bus_rd(A_STAT, d);
		chk(d | 32'(irq), 32'h0, "stat clear");
	endtask : run_meas
	// shield follows drive in self mode only
	always @(negedge ref_clk) begin
		if (rstn)
			chk({30'h0, shield_out, nonmeas_out}, {30'h0, {2{drive_pulse & shld}}}, "shield");
	end
	initial begin
		repeat (80000) @(posedge ref_clk);
		n_fail++;
		end_sim();
	end
	initial begin
		logic [31:0] d;
		int i;
		repeat (2) @(posedge ref_clk);
		rstn <= 1'b1;
		bus_wr(6'h3C, 32'hFFFF_FFFF);
		for (i = 0; i < 8; i++) begin
			bus_rd(ra[i], d);
			chk(d, rv[i], "reset");
		end
		// Strobe lost while the clock enable is low
		ce <= 1'b0;
		bus_wr(A_THR, 32'h0000_1234);
		ce <= 1'b1;
		bus_rd(A_THR, d);
		chk(d, {16'h0, THR_RST}, "ce hold");
		bus_wr(A_CFG, 32'h30AF);
		for (i = 0; i < 10; i++)
			run_diag(i);
		// host rests about 1 ms after diagnosis
		repeat (50000) @(posedge ref_clk);
		for (i = 0; i < 10; i++)
			run_meas(i % 3, int'(i % 5 > 0 && i % 5 < 4), (i % 5 == 0) ? 0 : i % 5 - 1, 0,
				2'((i % 5 == 2) ? 1 : (i % 5 == 4) ? 2 : 0));
		// window of two on a fresh channel
		run_meas(3, 0, 0, 1, 2'h3);
		run_meas(3, 0, 0, 1, 2'h0);
		end_sim();
	end
endmodule : mft_touch_bench
`default_nettype wire
